/* ocpwm_channel.sv */
// Output compare and PWM channel with two timebases and an APB register slave.
//
// Contract
// - Continuous pulses start low, pulse every period.
// - Pulse modes: primary match drives output high.
// - Pulse modes: secondary match drives output low.
// - Continuous mode flags interrupt on secondary match.
// - Period match wraps timebase count to zero.
// - Primary register read-only in PWM modes.
// - Secondary copied to duty on period match.
// - Primary value sets first PWM period duty.
// - Period setting N gives N+1 counts.
// - Zero duty keeps output low.
// - Duty above period keeps output high.
// - Duty equal period: low one count.
// - Code 111 PWM with fault, 110 without.
// - Code 011 toggles output on match.
// - Code 010 starts high, match forces low.
// - Code 001 starts low, match forces high.
// - Code 000 disables the channel.
// - Fault status bit 4 hardware set/cleared.
// - Select bit 3 picks second timer.
// - Idle halt bit 13 stops channel in idle.
// - Fault A serves channels 1-4, B 5-8.
// - Single pulse ends low, no further pulses.
`timescale 1ns/1ns
module ocpwm_channel #(
  parameter int CHANNEL_NUM = 1
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [ocpwm_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ocpwm_pkg::DATA_W-1:0] pwdata,
  output logic [ocpwm_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // System status and shared fault inputs, active high.
  input wire logic cpu_idle,
  input wire logic fault_input_a,
  input wire logic fault_input_b,
  // Channel outputs.
  output logic compare_out_pin,
  output logic compare_irq_flag
);
  import ocpwm_pkg::*;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Control register fields.
  logic idle_halt_sel_q; // Halt while the CPU idles.
  logic timebase_select_q; // Set picks the second timebase.
  logic [2:0] compare_mode_sel_q; // Current mode code.
  logic pwm_fault_status_q; // Fault seen in fault-enabled PWM.
  // Compare values and timebases.
  logic [CNT_W-1:0] compare_primary_q; // Compare value, or active duty in PWM.
  logic [CNT_W-1:0] compare_secondary_q; // Trailing edge, or buffered duty in PWM.
  logic [1:0] timer_run_q; // Run bits of both timebases.
  logic [CNT_W-1:0] timebase_period_q [2]; // Period of each timebase.
  logic [CNT_W-1:0] timebase_count_q [2]; // Count of each timebase.
  logic [1:0] period_hit; // Running timebase at its period.
  // Channel state.
  ocpwm_pulse_state_t pulse_q; // Pulse progress.
  logic out_q; // Registered pin level.
  logic irq_q; // One-cycle interrupt request.
  logic [DATA_W-1:0] prdata_q; // Read data captured in the setup phase.
  logic err_q; // Unmapped address seen in the setup phase.

  // Bus decode: registers answer in the first access cycle, no wait states.
  logic setup_ph;
  logic wr_en;
  logic ctrl_wr;
  logic mapped;
  logic [2:0] new_mode;
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pwrite && !err_q;
  assign ctrl_wr = wr_en && (paddr == OFS_CTRL);
  assign new_mode = pwdata[CTL_MODE_MSB:CTL_MODE_LSB];
  assign pready = penable;
  assign pslverr = psel && penable && err_q;
  assign prdata = prdata_q;

  // Address decode of the whole map.
  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_PRIMARY, OFS_SECONDARY, OFS_TMR_RUN: mapped = 1'b1;
      OFS_PERIOD0, OFS_PERIOD1, OFS_COUNT0, OFS_COUNT1: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Mode groups and the selected timebase.
  logic is_pwm;
  logic is_pulse;
  logic halted;
  logic sel_tick;
  logic sel_wrap;
  logic [CNT_W-1:0] sel_count;
  logic [CNT_W-1:0] sel_period;
  logic match_pri;
  logic match_sec;
  logic fault_pin;
  logic fault_evt;
  assign is_pwm = (compare_mode_sel_q == MODE_PWM) || (compare_mode_sel_q == MODE_PWM_FLT);
  assign is_pulse = (compare_mode_sel_q == MODE_SINGLE) || (compare_mode_sel_q == MODE_CONT);
  assign halted = idle_halt_sel_q && cpu_idle;
  assign sel_count = timebase_count_q[timebase_select_q];
  assign sel_period = timebase_period_q[timebase_select_q];
  assign sel_tick = timer_run_q[timebase_select_q] && !halted;
  assign sel_wrap = period_hit[timebase_select_q] && !halted;
  // Each count value is present for exactly one running cycle, so a match fires once.
  assign match_pri = sel_tick && (sel_count == compare_primary_q);
  assign match_sec = sel_tick && (sel_count == compare_secondary_q);
  // Low channels follow the first fault input, high channels the second.
  assign fault_pin = (CHANNEL_NUM <= FAULT_A_LAST_CH) ? fault_input_a : fault_input_b;
  assign fault_evt = (compare_mode_sel_q == MODE_PWM_FLT) && fault_pin && !halted;

  // Setup-phase capture of read data and of the error answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup_ph) begin
      err_q <= !mapped;
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        OFS_CTRL: begin
          prdata_q[CTL_IDLE_BIT] <= idle_halt_sel_q;
          prdata_q[CTL_FAULT_BIT] <= pwm_fault_status_q;
          prdata_q[CTL_TSEL_BIT] <= timebase_select_q;
          prdata_q[CTL_MODE_MSB:CTL_MODE_LSB] <= compare_mode_sel_q;
        end
        OFS_PRIMARY: prdata_q[CNT_W-1:0] <= compare_primary_q;
        OFS_SECONDARY: prdata_q[CNT_W-1:0] <= compare_secondary_q;
        OFS_TMR_RUN: prdata_q[1:0] <= timer_run_q;
        OFS_PERIOD0: prdata_q[CNT_W-1:0] <= timebase_period_q[0];
        OFS_PERIOD1: prdata_q[CNT_W-1:0] <= timebase_period_q[1];
        OFS_COUNT0: prdata_q[CNT_W-1:0] <= timebase_count_q[0];
        OFS_COUNT1: prdata_q[CNT_W-1:0] <= timebase_count_q[1];
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Writable control fields; writing the control word also restarts the mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_halt_sel_q <= 1'b0;
      timebase_select_q <= 1'b0;
      compare_mode_sel_q <= MODE_RST;
    end else if (ctrl_wr) begin
      idle_halt_sel_q <= pwdata[CTL_IDLE_BIT];
      timebase_select_q <= pwdata[CTL_TSEL_BIT];
      compare_mode_sel_q <= new_mode;
    end
  end

  // Fault status: software cannot write it. It is set by a fault and cleared by
  // hardware once the channel is in any mode other than fault-enabled PWM; the set
  // wins a tie. A mode write that lands while the fault pin is still active sets the
  // bit once more, so the clear also follows the current mode on the next edge;
  // otherwise the control word would keep reporting a stale fault in the fault-free PWM mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_fault_status_q <= 1'b0;
    end else if (fault_evt) begin
      pwm_fault_status_q <= 1'b1;
    end else if ((ctrl_wr && (new_mode != MODE_PWM_FLT))
        || (compare_mode_sel_q != MODE_PWM_FLT)) begin
      pwm_fault_status_q <= 1'b0;
    end
  end

  // Timebases: run bits and periods written by software, counts free-running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_run_q <= 2'h0;
    end else if (wr_en && (paddr == OFS_TMR_RUN)) begin
      timer_run_q <= pwdata[1:0];
    end
  end

  // One counter per timebase; the period match returns the count to zero.
  for (genvar t = 0; t < 2; t++) begin : g_tb
    assign period_hit[t] = timer_run_q[t] && (timebase_count_q[t] == timebase_period_q[t]);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        timebase_period_q[t] <= PERIOD_RST;
        timebase_count_q[t] <= 16'h0000;
      end else begin
        if (wr_en && (paddr == ((t == 0) ? OFS_PERIOD0 : OFS_PERIOD1))) begin
          timebase_period_q[t] <= pwdata[CNT_W-1:0];
        end
        if (period_hit[t]) begin
          timebase_count_q[t] <= 16'h0000;
        end else if (timer_run_q[t]) begin
          timebase_count_q[t] <= timebase_count_q[t] + 16'h0001;
        end
      end
    end
    // The counter restarts from zero right after its period value.
    a_timer_wrap: assert property (period_hit[t] |=> timebase_count_q[t] == 16'h0000)
      else $error("timebase did not wrap to zero after period match");
  end

  // Secondary compare: always writable, it buffers the next duty in PWM.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_secondary_q <= CMP_RST;
    end else if (wr_en && (paddr == OFS_SECONDARY)) begin
      compare_secondary_q <= pwdata[CNT_W-1:0];
    end
  end

  // Primary compare: software owns it outside PWM; in PWM it is the active
  // duty and only the period match reloads it, which keeps the waveform glitchless.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_primary_q <= CMP_RST;
    end else if (is_pwm) begin
      if (sel_wrap) begin
        compare_primary_q <= compare_secondary_q;
      end
    end else if (wr_en && (paddr == OFS_PRIMARY)) begin
      compare_primary_q <= pwdata[CNT_W-1:0];
    end
  end

  // Pulse progress for the single and continuous pulse modes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= PS_IDLE;
    end else if (ctrl_wr) begin
      // Any write of a pulse code arms a fresh sequence, even in the same mode.
      pulse_q <= ((new_mode == MODE_SINGLE) || (new_mode == MODE_CONT)) ? PS_WAIT_RISE : PS_IDLE;
    end else if (is_pulse) begin
      unique case (pulse_q)
        PS_WAIT_RISE: begin
          if (match_pri) begin
            pulse_q <= PS_WAIT_FALL;
          end
        end
        PS_WAIT_FALL: begin
          if (match_sec) begin
            pulse_q <= (compare_mode_sel_q == MODE_CONT) ? PS_WAIT_RISE : PS_DONE;
          end
        end
        PS_IDLE, PS_DONE: pulse_q <= pulse_q;
      endcase
    end
  end

  // Output pin level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (ctrl_wr) begin
      // Entering a mode sets the initial level; only the fall-on-match mode starts high.
      out_q <= (new_mode == MODE_FALL);
    end else if (!halted) begin
      unique case (compare_mode_sel_q)
        MODE_OFF: out_q <= 1'b0;
        MODE_RISE: begin
          if (match_pri) begin
            out_q <= 1'b1;
          end
        end
        MODE_FALL: begin
          if (match_pri) begin
            out_q <= 1'b0;
          end
        end
        MODE_TOGGLE: begin
          if (match_pri) begin
            out_q <= !out_q;
          end
        end
        MODE_SINGLE, MODE_CONT: begin
          if ((pulse_q == PS_WAIT_FALL) && match_sec) begin
            out_q <= 1'b0;
          end else if ((pulse_q == PS_WAIT_RISE) && match_pri) begin
            out_q <= 1'b1;
          end else if (pulse_q == PS_DONE) begin
            out_q <= 1'b0;
          end
        end
        MODE_PWM, MODE_PWM_FLT: begin
          // High while count is below duty: zero gives 0%, above period gives 100%,
          // equal to period leaves exactly the last count low.
          // A latched fault only holds the pin in the fault-enabled mode.
          if (fault_evt || ((compare_mode_sel_q == MODE_PWM_FLT) && pwm_fault_status_q)) begin
            out_q <= 1'b0;
          end else begin
            out_q <= (sel_count < compare_primary_q);
          end
        end
      endcase
    end
  end

  // Interrupt request: end of each pulse, each simple compare match, a new fault.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (!ctrl_wr && is_pulse && (pulse_q == PS_WAIT_FALL) && match_sec)
        || (!ctrl_wr && !is_pwm && !is_pulse && (compare_mode_sel_q != MODE_OFF) && match_pri)
        || (fault_evt && !pwm_fault_status_q);
    end
  end

  assign compare_out_pin = out_q;
  assign compare_irq_flag = irq_q;

  // Checks on the channel behaviour.
  sequence s_pulse_start;
    is_pulse && !ctrl_wr && (pulse_q == PS_WAIT_RISE) && match_pri && !match_sec;
  endsequence
  sequence s_pulse_end;
    is_pulse && !ctrl_wr && (pulse_q == PS_WAIT_FALL) && match_sec;
  endsequence
  sequence s_fault_hit;
    fault_evt && !ctrl_wr;
  endsequence

  a_pulse_rise: assert property (s_pulse_start |=> out_q && (pulse_q == PS_WAIT_FALL))
    else $error("pulse did not rise on primary match");
  a_pulse_fall_irq: assert property (s_pulse_end |=> !out_q && irq_q)
    else $error("pulse did not fall with interrupt on secondary match");
  a_cont_rearm: assert property (s_pulse_end and (compare_mode_sel_q == MODE_CONT)
    |=> pulse_q == PS_WAIT_RISE)
    else $error("continuous mode did not re-arm after pulse");
  a_single_stays_low: assert property (((compare_mode_sel_q == MODE_SINGLE)
    && (pulse_q == PS_DONE) && !ctrl_wr) [*2] |-> !out_q)
    else $error("single pulse mode left low state after end");
  a_duty_reload: assert property (is_pwm && sel_wrap && !ctrl_wr
    |=> compare_primary_q == $past(compare_secondary_q))
    else $error("duty not reloaded at period match");
  a_primary_locked: assert property (is_pwm && !sel_wrap && !ctrl_wr
    |=> $stable(compare_primary_q))
    else $error("primary changed in PWM outside period match");
  a_zero_duty: assert property (is_pwm && !halted && !ctrl_wr
    && (compare_primary_q == 16'h0000) |=> !out_q)
    else $error("zero duty drove output high");
  a_full_duty: assert property (is_pwm && !halted && !ctrl_wr && !fault_evt
    && !pwm_fault_status_q && (compare_primary_q > sel_period) |=> out_q)
    else $error("duty above period drove output low");
  a_fault_force: assert property (s_fault_hit |=> pwm_fault_status_q && !out_q)
    else $error("fault did not force output low and set status");
  // Leaving the fault-enabled mode drains the status bit within one edge, even when
  // the fault pin is still active, so the fault-free mode reports no stale fault status.
  a_fault_clear: assert property ((compare_mode_sel_q != MODE_PWM_FLT)
    |=> !pwm_fault_status_q)
    else $error("fault status survived outside fault-enabled PWM");
  a_toggle_match: assert property ((compare_mode_sel_q == MODE_TOGGLE) && match_pri
    && !ctrl_wr |=> out_q != $past(out_q))
    else $error("toggle mode did not invert output");
  a_mode_off: assert property ((compare_mode_sel_q == MODE_OFF) && !halted && !ctrl_wr
    |=> !out_q && !irq_q)
    else $error("disabled channel drove output or interrupt");
  a_idle_freeze: assert property (halted && !ctrl_wr |=> $stable(out_q))
    else $error("output moved while halted in idle");

endmodule : ocpwm_channel

/* ocpwm_pkg.sv */
// Package with register map, field layout, mode codes and states of the compare channel.
package ocpwm_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRIMARY = 8'h04;
  localparam logic [7:0] OFS_SECONDARY = 8'h08;
  localparam logic [7:0] OFS_TMR_RUN = 8'h0c;
  localparam logic [7:0] OFS_PERIOD0 = 8'h10;
  localparam logic [7:0] OFS_PERIOD1 = 8'h14;
  localparam logic [7:0] OFS_COUNT0 = 8'h18;
  localparam logic [7:0] OFS_COUNT1 = 8'h1c;

  // Control register field positions.
  localparam int CTL_IDLE_BIT = 13;
  localparam int CTL_FAULT_BIT = 4;
  localparam int CTL_TSEL_BIT = 3;
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_MODE_MSB = 2;

  // Reset values.
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hffff;
  localparam logic [2:0] MODE_RST = 3'h0;

  // Mode codes of the mode field.
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_RISE = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_SINGLE = 3'h4;
  localparam logic [2:0] MODE_CONT = 3'h5;
  localparam logic [2:0] MODE_PWM = 3'h6;
  localparam logic [2:0] MODE_PWM_FLT = 3'h7;

  // Highest channel number served by the first fault input.
  localparam int FAULT_A_LAST_CH = 4;

  // Progress of a single or continuous pulse.
  typedef enum logic [1:0] {
    PS_IDLE,
    PS_WAIT_RISE,
    PS_WAIT_FALL,
    PS_DONE
  } ocpwm_pulse_state_t;

endpackage : ocpwm_pkg

/* ocpwm_load.sv */
// Passive load on the compare output pin that times its pulses.
`timescale 1ns/1ns
module ocpwm_load (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Observed output pin.
  input wire logic pin,
  // Pulse measurements.
  output logic [15:0] rise_cnt,
  output logic [15:0] high_len,
  output logic [15:0] per_len,
  output logic [15:0] still
);
  logic prev_q; // Pin level seen at the previous edge.
  logic [15:0] hi_q; // Length of the high phase in progress.
  logic [15:0] per_q; // Cycles since the last rising edge.

  // The load drives nothing back, so a bad duty can never be masked by it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      hi_q <= 16'h0000;
      per_q <= 16'h0000;
      rise_cnt <= 16'h0000;
      high_len <= 16'h0000;
      per_len <= 16'h0000;
      still <= 16'h0000;
    end else begin
      prev_q <= pin;
      still <= (pin !== prev_q) ? 16'h0001 : still + 16'h0001;
      hi_q <= pin ? (prev_q ? hi_q + 16'h0001 : 16'h0001) : hi_q;
      per_q <= (pin && !prev_q) ? 16'h0001 : per_q + 16'h0001;
      if (pin && !prev_q) begin
        rise_cnt <= rise_cnt + 16'h0001;
        per_len <= per_q;
      end
      if (!pin && prev_q) begin
        high_len <= hi_q;
      end
    end
  end
endmodule : ocpwm_load

/* ocpwm_channel_tb.sv */
// Self-checking bench for the compare channel, driven over APB.
`timescale 1ns/1ns
module ocpwm_channel_tb;
  import ocpwm_pkg::*;
  logic pclk = 1'b0; // Bus clock, 4 ns period.
  logic presetn = 1'b0; // Active-low reset.
  logic [ADDR_W-1:0] paddr = '0; // APB request.
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata; // APB answer.
  logic pready;
  logic pslverr;
  logic cpu_idle = 1'b0; // System status and fault stimulus.
  logic fault_input_a = 1'b0;
  logic fault_input_b = 1'b0;
  logic compare_out_pin; // Channel outputs.
  logic compare_irq_flag;
  logic [15:0] rise_cnt, high_len, per_len, still; // Load measurements.
  logic [31:0] rdata; // Data of the last transfer.
  logic err; // Error response of the last transfer.
  int num_errors = 0;
  int total_checks = 0;
  int irq_cnt = 0; // Interrupt pulses seen so far.
  int r0; // Snapshots of the counters.
  int i0;

  // Free-running clock.
  always #2 pclk = ~pclk;

  // Counted by non-blocking update so that snapshots taken at an edge agree.
  always @(posedge pclk) begin
    if (compare_irq_flag === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end

  ocpwm_channel #(.CHANNEL_NUM(1)) u_ocpwm_channel (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
    .fault_input_a(fault_input_a), .fault_input_b(fault_input_b),
    .compare_out_pin(compare_out_pin), .compare_irq_flag(compare_irq_flag));

  ocpwm_load u_ocpwm_load (.pclk(pclk), .presetn(presetn), .pin(compare_out_pin),
    .rise_cnt(rise_cnt), .high_len(high_len), .per_len(per_len), .still(still));

  // One APB transfer; the request stands until pready is seen at an edge.
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits a number of clock edges.
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Holds reset for three cycles.
  task do_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  // Prints the counts and the verdict, then ends the run.
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  initial begin
    do_reset();
    // Reset values and an unmapped address.
    xfer(0, OFS_CTRL, '0);
    chk(32'h0, rdata);
    xfer(0, OFS_PERIOD0, '0);
    chk({16'h0, PERIOD_RST}, rdata);
    xfer(0, 8'h20, '0);
    chk(32'h1, {31'h0, err});
    chk(32'h0, rdata);
    // Continuous pulses: rise at 2, fall at 4, period of six counts.
    xfer(1, OFS_PRIMARY, 32'h2);
    xfer(1, OFS_SECONDARY, 32'h4);
    xfer(1, OFS_PERIOD0, 32'h5);
    xfer(1, OFS_CTRL, 32'(MODE_CONT));
    chk(32'h0, {31'h0, compare_out_pin});
    xfer(1, OFS_TMR_RUN, 32'h1);
    cyc(20);
    chk(32'h2, {16'h0, high_len});
    chk(32'h6, {16'h0, per_len});
    i0 = irq_cnt;
    cyc(36);
    chk(32'h6, 32'(irq_cnt - i0));
    xfer(0, OFS_COUNT0, '0);
    chk(32'h1, 32'(rdata <= 32'h5));
    // Second timer select and idle halt; only odd steps may pulse.
    xfer(1, OFS_PERIOD1, 32'h5);
    xfer(1, OFS_TMR_RUN, 32'h2);
    for (int k = 0; k < 4; k++) begin
      cpu_idle <= (k >= 2);
      xfer(1, OFS_CTRL, 32'(MODE_CONT) | (32'(k != 0) << CTL_TSEL_BIT)
        | (32'(k == 2) << CTL_IDLE_BIT));
      r0 = rise_cnt;
      cyc(20);
      chk(32'(k % 2), 32'(rise_cnt != r0));
    end
    cpu_idle <= 1'b0;
    // Single pulse, written twice to re-arm it.
    xfer(1, OFS_TMR_RUN, 32'h3);
    for (int k = 0; k < 2; k++) begin
      xfer(1, OFS_CTRL, 32'(MODE_SINGLE));
      r0 = rise_cnt;
      cyc(30);
      chk(32'h1, 32'(rise_cnt - r0));
      chk(32'h2, {16'h0, high_len});
      chk(32'h0, {31'h0, compare_out_pin});
    end
    // Off, force high, force low and toggle, each entered with the timer stopped.
    for (int k = 0; k < 4; k++) begin
      xfer(1, OFS_TMR_RUN, 32'h0);
      xfer(1, OFS_CTRL, 32'(3'(k)));
      cyc(2);
      chk(32'(k == 2), {31'h0, compare_out_pin});
      r0 = rise_cnt;
      xfer(1, OFS_TMR_RUN, 32'h1);
      cyc(30);
      chk(32'(k == 1 || k == 3), 32'(rise_cnt != r0));
      if (k < 3) chk(32'(k == 1), {31'h0, compare_out_pin});
      if (k == 3) chk(32'd12, {16'h0, per_len});
    end
    // PWM after a second reset: first duty from primary, then secondary of zero.
    do_reset();
    xfer(1, OFS_PERIOD0, 32'h7);
    xfer(1, OFS_PRIMARY, 32'h3);
    xfer(1, OFS_CTRL, 32'(MODE_PWM));
    xfer(1, OFS_TMR_RUN, 32'h1);
    cyc(30);
    chk(32'h1, {16'h0, rise_cnt});
    chk(32'h0, {31'h0, compare_out_pin});
    xfer(1, OFS_SECONDARY, 32'h9);
    cyc(20);
    chk(32'h1, {31'h0, compare_out_pin});
    chk(32'h1, 32'(still >= 16'd9));
    xfer(1, OFS_SECONDARY, 32'h7);
    xfer(1, OFS_PRIMARY, 32'h2);
    // The reload may wait a whole period, then two full periods must be timed.
    cyc(30);
    chk(32'h7, {16'h0, high_len});
    chk(32'h8, {16'h0, per_len});
    xfer(0, OFS_PRIMARY, '0);
    chk(32'h7, rdata);
    // Fault handling: the second input must not touch channel one.
    xfer(1, OFS_CTRL, 32'(MODE_PWM_FLT));
    fault_input_b <= 1'b1;
    r0 = rise_cnt;
    cyc(20);
    chk(32'h1, 32'(rise_cnt != r0));
    i0 = irq_cnt;
    fault_input_a <= 1'b1;
    cyc(20);
    chk(32'h1, 32'(irq_cnt - i0));
    chk(32'h0, {31'h0, compare_out_pin});
    xfer(0, OFS_CTRL, '0);
    chk(32'h1, 32'(rdata[CTL_FAULT_BIT]));
    xfer(1, OFS_CTRL, 32'(MODE_PWM));
    xfer(0, OFS_CTRL, '0);
    chk(32'(MODE_PWM), rdata);
    r0 = rise_cnt;
    cyc(20);
    chk(32'h1, 32'(rise_cnt != r0));
    give_verdict();
  end

  // Cuts a hung run short; the sequence needs well under 2000 cycles.
  initial begin
    #40000;
    num_errors++;
    give_verdict();
  end
endmodule : ocpwm_channel_tb
